// ==== src/lrw_defs.svh ====
// How it works
// - Command 25h loads next byte as contrast
// - Host sends contrast 0..127, top bit zero
// - Bigger contrast raises voltage; reset to 63
// - Command 28h blanks segments; RAM access goes on
// - Command 29h shows RAM; display off after reset
// - Command 2Ah takes first then last column
// - Column scan wraps to first, page advances
// - Host sets both columns, first below last
// - Writes outside physical RAM are dropped
// - Reset columns: 0 to 103, or 97
// - Command 2Bh sets pages; page scan wraps
// - Reset pages: 0 to 83, or 66
// - Host sets both pages, first below last
// - Command 2Ch rewinds pointers, stores data bytes
// - Pixel write lasts until any command byte
// - Command 2Dh loads 8 red, 8 green, 4 blue
// - Table expands RRRGGGBB only in 256-colour mode
// - Host loads whole table before 256-colour use
// - Command 2Eh rewinds pointers, reads and advances
`ifndef LRW_DEFS_SVH
`define LRW_DEFS_SVH
`define LRW_CMD_CONTRAST 8'h25
`define LRW_CMD_DISP_OFF 8'h28
`define LRW_CMD_DISP_ON 8'h29
`define LRW_CMD_COL_WIN 8'h2A
`define LRW_CMD_PAGE_WIN 8'h2B
`define LRW_CMD_PIX_WRITE 8'h2C
`define LRW_CMD_LUT_LOAD 8'h2D
`define LRW_CMD_PIX_READ 8'h2E
`define LRW_CONTRAST_RST 7'h3F
`define LRW_COL_LAST_LO 8'h67
`define LRW_COL_LAST_HI 8'h61
`define LRW_PAGE_LAST_LO 8'h53
`define LRW_PAGE_LAST_HI 8'h42
`define LRW_LUT_GREEN 5'h08
`define LRW_LUT_BLUE 5'h10
`define LRW_LUT_SIZE 5'h14
`define LRW_OFS_TX 12'h000
`define LRW_OFS_RD 12'h004
`define LRW_OFS_STATUS 12'h008
`define LRW_TX_DC_BIT 8
`define LRW_ST_VALID_BIT 8
`define LRW_ST_ORDER_BIT 9
`define LRW_ST_LUT_BIT 10
`endif

// ==== src/lrw_pkg.sv ====
package lrw_pkg;
   typedef enum logic [8:0] {
      LRW_IDLE = 9'h001,
      LRW_CONTRAST = 9'h002,
      LRW_COL1 = 9'h004,
      LRW_COL2 = 9'h008,
      LRW_PAGE1 = 9'h010,
      LRW_PAGE2 = 9'h020,
      LRW_PIXWR = 9'h040,
      LRW_LUT = 9'h080,
      LRW_PIXRD = 9'h100
   } lrw_state_t;
endpackage : lrw_pkg

// ==== src/lrw_if.sv ====
`timescale 1ns/100ps
interface lrw_if;
   logic dc;
   logic wr_stb;
   logic [7:0] wdata;
   logic rd_stb;
   logic [7:0] rdata;
   logic rd_valid;
   modport dev (input dc, input wr_stb, input wdata, input rd_stb, output rdata, output rd_valid);
   modport host (output dc, output wr_stb, output wdata, output rd_stb, input rdata, input rd_valid);
endinterface : lrw_if

// ==== src/lrw_device.sv ====
`timescale 1ns/100ps
`include "lrw_defs.svh"
module lrw_device
   import lrw_pkg::*;
#(
   parameter int NUM_COLS = 104,
   parameter int NUM_PAGES = 84
) (
   input wire logic CLK,
   input wire logic SRST,
   lrw_if.dev LINK,
   input wire logic RAM_PARTITION_STRAP,
   input wire logic PAGE_SCAN,
   input wire logic COLOUR_256,
   input wire logic [7:0] PIX_INDEX,
   output logic [6:0] CONTRAST,
   output logic DISPLAY_ON,
   output logic SEG_OFF,
   output logic [3:0] PIX_R,
   output logic [3:0] PIX_G,
   output logic [3:0] PIX_B
);
   localparam int AW = $clog2(NUM_COLS * NUM_PAGES);

   lrw_state_t state_q, state_d;
   logic [6:0] contrast_q, contrast_d;
   logic disp_q, disp_d;
   logic [7:0] col_first_q, col_first_d, col_last_q, col_last_d;
   logic [7:0] page_first_q, page_first_d, page_last_q, page_last_d;
   logic [7:0] col_q, col_d, page_q, page_d;
   logic [4:0] lut_idx_q, lut_idx_d;
   logic lut_we;
   logic we_q, we_d;
   logic [AW-1:0] waddr_q, waddr_d;
   logic [7:0] wbyte_q, wbyte_d;
   logic [7:0] rdata_q, rdata_d;
   logic rd_valid_q, rd_valid_d;
   logic [3:0] pr_q, pr_d, pg_q, pg_d, pb_q, pb_d;
   logic [7:0] ram [NUM_COLS * NUM_PAGES];
   logic [3:0] lut [20];
   logic in_range;
   logic [AW-1:0] addr;
   logic adv;

   assign in_range = (32'(col_q) < NUM_COLS) && (32'(page_q) < NUM_PAGES);
   assign addr = AW'(32'(page_q) * NUM_COLS + 32'(col_q));

   always_comb begin
      state_d = state_q;
      contrast_d = contrast_q;
      disp_d = disp_q;
      col_first_d = col_first_q;
      col_last_d = col_last_q;
      page_first_d = page_first_q;
      page_last_d = page_last_q;
      col_d = col_q;
      page_d = page_q;
      lut_idx_d = lut_idx_q;
      lut_we = 1'b0;
      we_d = 1'b0;
      waddr_d = waddr_q;
      wbyte_d = wbyte_q;
      rdata_d = rdata_q;
      rd_valid_d = 1'b0;
      adv = 1'b0;
      if (LINK.wr_stb && !LINK.dc) begin
         // Any command ends a pending write or read stream
         state_d = LRW_IDLE;
         case (LINK.wdata)
            `LRW_CMD_CONTRAST: state_d = LRW_CONTRAST;
            `LRW_CMD_DISP_OFF: disp_d = 1'b0;
            `LRW_CMD_DISP_ON: disp_d = 1'b1;
            `LRW_CMD_COL_WIN: state_d = LRW_COL1;
            `LRW_CMD_PAGE_WIN: state_d = LRW_PAGE1;
            `LRW_CMD_PIX_WRITE: begin
               col_d = col_first_q;
               page_d = page_first_q;
               state_d = LRW_PIXWR;
            end
            `LRW_CMD_LUT_LOAD: begin
               lut_idx_d = '0;
               state_d = LRW_LUT;
            end
            `LRW_CMD_PIX_READ: begin
               col_d = col_first_q;
               page_d = page_first_q;
               state_d = LRW_PIXRD;
            end
            default: begin
            end
         endcase
      end else if (LINK.wr_stb) begin
         case (state_q)
            LRW_CONTRAST: begin
               // Top bit is the host's to keep zero, so it is simply not stored
               contrast_d = LINK.wdata[6:0];
               state_d = LRW_IDLE;
            end
            LRW_COL1: begin
               col_first_d = LINK.wdata;
               state_d = LRW_COL2;
            end
            LRW_COL2: begin
               col_last_d = LINK.wdata;
               state_d = LRW_IDLE;
            end
            LRW_PAGE1: begin
               page_first_d = LINK.wdata;
               state_d = LRW_PAGE2;
            end
            LRW_PAGE2: begin
               page_last_d = LINK.wdata;
               state_d = LRW_IDLE;
            end
            LRW_PIXWR: begin
               we_d = in_range;
               waddr_d = addr;
               wbyte_d = LINK.wdata;
               adv = 1'b1;
            end
            LRW_LUT: begin
               // Surplus bytes past the last blue entry are ignored
               if (lut_idx_q < `LRW_LUT_SIZE) begin
                  lut_we = 1'b1;
                  lut_idx_d = lut_idx_q + 5'h01;
               end
            end
            default: begin
            end
         endcase
      end else if (LINK.rd_stb && state_q == LRW_PIXRD) begin
         // Outside the RAM the answer is zero, not real data
         rdata_d = in_range ? ram[addr] : 8'h00;
         rd_valid_d = 1'b1;
         adv = 1'b1;
      end
      if (adv) begin
         if (!PAGE_SCAN) begin
            if (col_q == col_last_q) begin
               col_d = col_first_q;
               page_d = page_q + 8'h01;
            end else begin
               col_d = col_q + 8'h01;
            end
         end else begin
            if (page_q == page_last_q) begin
               page_d = page_first_q;
               col_d = col_q + 8'h01;
            end else begin
               page_d = page_q + 8'h01;
            end
         end
      end
   end

   always_comb begin
      pr_d = 4'h0;
      pg_d = 4'h0;
      pb_d = 4'h0;
      // Segments sit at the off level while the display is off
      if (disp_q) begin
         if (COLOUR_256) begin
            pr_d = lut[{2'b00, PIX_INDEX[7:5]}];
            pg_d = lut[`LRW_LUT_GREEN + {2'b00, PIX_INDEX[4:2]}];
            pb_d = lut[`LRW_LUT_BLUE + {3'b000, PIX_INDEX[1:0]}];
         end else begin
            pr_d = {PIX_INDEX[7:5], 1'b0};
            pg_d = {PIX_INDEX[4:2], 1'b0};
            pb_d = {PIX_INDEX[1:0], 2'b00};
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_q <= LRW_IDLE;
         contrast_q <= `LRW_CONTRAST_RST;
         disp_q <= 1'b0;
         col_first_q <= 8'h00;
         col_last_q <= RAM_PARTITION_STRAP ? `LRW_COL_LAST_HI : `LRW_COL_LAST_LO;
         page_first_q <= 8'h00;
         page_last_q <= RAM_PARTITION_STRAP ? `LRW_PAGE_LAST_HI : `LRW_PAGE_LAST_LO;
         col_q <= 8'h00;
         page_q <= 8'h00;
         lut_idx_q <= 5'h00;
         we_q <= 1'b0;
         waddr_q <= '0;
         wbyte_q <= 8'h00;
         rdata_q <= 8'h00;
         rd_valid_q <= 1'b0;
         pr_q <= 4'h0;
         pg_q <= 4'h0;
         pb_q <= 4'h0;
      end else begin
         state_q <= state_d;
         contrast_q <= contrast_d;
         disp_q <= disp_d;
         col_first_q <= col_first_d;
         col_last_q <= col_last_d;
         page_first_q <= page_first_d;
         page_last_q <= page_last_d;
         col_q <= col_d;
         page_q <= page_d;
         lut_idx_q <= lut_idx_d;
         we_q <= we_d;
         waddr_q <= waddr_d;
         wbyte_q <= wbyte_d;
         rdata_q <= rdata_d;
         rd_valid_q <= rd_valid_d;
         pr_q <= pr_d;
         pg_q <= pg_d;
         pb_q <= pb_d;
      end
   end

   // Storage arrays carry no reset; the table is undefined until loaded
   always_ff @(posedge CLK) begin
      if (we_q) begin
         ram[waddr_q] <= wbyte_q;
      end
      if (lut_we) begin
         lut[lut_idx_q] <= LINK.wdata[3:0];
      end
   end

   assign LINK.rdata = rdata_q;
   assign LINK.rd_valid = rd_valid_q;
   assign CONTRAST = contrast_q;
   assign DISPLAY_ON = disp_q;
   assign SEG_OFF = !disp_q;
   assign PIX_R = pr_q;
   assign PIX_G = pg_q;
   assign PIX_B = pb_q;
endmodule : lrw_device

// ==== src/lrw_host.sv ====
`timescale 1ns/100ps
`include "lrw_defs.svh"
module lrw_host
   import lrw_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   lrw_if.host LINK
);
   logic mapped, acc, setup;
   logic wr_stb_q, wr_stb_d, dc_q, dc_d, rd_stb_q, rd_stb_d;
   logic [7:0] wdata_q, wdata_d, last_cmd_q, last_cmd_d, first_q, first_d, rx_q, rx_d;
   logic [1:0] pcnt_q, pcnt_d;
   logic [4:0] lut_cnt_q, lut_cnt_d;
   logic rx_valid_q, rx_valid_d, order_err_q, order_err_d;
   logic [31:0] prdata_q, prdata_d;
   logic [7:0] byte_out;

   assign mapped = (PADDR == `LRW_OFS_TX) || (PADDR == `LRW_OFS_RD) || (PADDR == `LRW_OFS_STATUS);
   assign setup = PSEL && !PENABLE;
   assign acc = PSEL && PENABLE;

   always_comb begin
      wr_stb_d = 1'b0;
      rd_stb_d = 1'b0;
      dc_d = dc_q;
      wdata_d = wdata_q;
      last_cmd_d = last_cmd_q;
      first_d = first_q;
      pcnt_d = pcnt_q;
      lut_cnt_d = lut_cnt_q;
      rx_d = rx_q;
      rx_valid_d = rx_valid_q;
      order_err_d = order_err_q;
      prdata_d = prdata_q;
      byte_out = PWDATA[7:0];
      if (acc && PWRITE && PADDR == `LRW_OFS_STATUS) begin
         if (PWDATA[`LRW_ST_ORDER_BIT]) begin
            order_err_d = 1'b0;
         end
         if (PWDATA[`LRW_ST_VALID_BIT]) begin
            rx_valid_d = 1'b0;
         end
      end
      if (acc && PWRITE && PADDR == `LRW_OFS_TX) begin
         // Select low marks a command byte
         if (!PWDATA[`LRW_TX_DC_BIT]) begin
            last_cmd_d = PWDATA[7:0];
            pcnt_d = 2'b00;
            if (PWDATA[7:0] == `LRW_CMD_LUT_LOAD) begin
               lut_cnt_d = 5'h00;
            end
         end else begin
            if (last_cmd_q == `LRW_CMD_CONTRAST) begin
               byte_out = {1'b0, PWDATA[6:0]};
            end
            if (last_cmd_q == `LRW_CMD_COL_WIN || last_cmd_q == `LRW_CMD_PAGE_WIN) begin
               if (pcnt_q == 2'b00) begin
                  first_d = PWDATA[7:0];
                  pcnt_d = 2'b01;
               end else if (pcnt_q == 2'b01) begin
                  // Flag a first/last pair not strictly rising
                  if (first_q >= PWDATA[7:0]) begin
                     order_err_d = 1'b1;
                  end
                  pcnt_d = 2'b10;
               end
            end
            if (last_cmd_q == `LRW_CMD_LUT_LOAD && lut_cnt_q < `LRW_LUT_SIZE) begin
               lut_cnt_d = lut_cnt_q + 5'h01;
            end
         end
         wr_stb_d = 1'b1;
         dc_d = PWDATA[`LRW_TX_DC_BIT];
         wdata_d = byte_out;
      end
      if (acc && PWRITE && PADDR == `LRW_OFS_RD) begin
         rd_stb_d = 1'b1;
      end
      // A returning byte sets the flag even in a clearing cycle
      if (LINK.rd_valid) begin
         rx_d = LINK.rdata;
         rx_valid_d = 1'b1;
      end
      if (setup && !PWRITE) begin
         if (PADDR == `LRW_OFS_STATUS) begin
            prdata_d = {21'h000000, lut_cnt_q == `LRW_LUT_SIZE, order_err_q, rx_valid_q, rx_q};
         end else begin
            prdata_d = 32'h00000000;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         wr_stb_q <= 1'b0;
         rd_stb_q <= 1'b0;
         dc_q <= 1'b0;
         wdata_q <= 8'h00;
         last_cmd_q <= 8'h00;
         first_q <= 8'h00;
         pcnt_q <= 2'b00;
         lut_cnt_q <= 5'h00;
         rx_q <= 8'h00;
         rx_valid_q <= 1'b0;
         order_err_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         wr_stb_q <= wr_stb_d;
         rd_stb_q <= rd_stb_d;
         dc_q <= dc_d;
         wdata_q <= wdata_d;
         last_cmd_q <= last_cmd_d;
         first_q <= first_d;
         pcnt_q <= pcnt_d;
         lut_cnt_q <= lut_cnt_d;
         rx_q <= rx_d;
         rx_valid_q <= rx_valid_d;
         order_err_q <= order_err_d;
         prdata_q <= prdata_d;
      end
   end

   assign PREADY = 1'b1;
   assign PSLVERR = acc && !mapped;
   assign PRDATA = prdata_q;
   assign LINK.wr_stb = wr_stb_q;
   assign LINK.rd_stb = rd_stb_q;
   assign LINK.dc = dc_q;
   assign LINK.wdata = wdata_q;
endmodule : lrw_host

// ==== tb/lrw_asserts.sv ====
`timescale 1ns/100ps
`include "lrw_defs.svh"
module lrw_asserts (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic dc,
   input wire logic wr_stb,
   input wire logic [7:0] wdata,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   input wire logic rd_valid
);
   logic rd_mode_q;
   logic rd_mode_d;
   logic ctr_q;
   logic ctr_d;
   // Mirrors the command state so the link can be judged without the bodies
   always_comb begin
      rd_mode_d = rd_mode_q;
      ctr_d = ctr_q;
      if (wr_stb) begin
         ctr_d = !dc && wdata == `LRW_CMD_CONTRAST;
         if (!dc) rd_mode_d = wdata == `LRW_CMD_PIX_READ;
      end
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         rd_mode_q <= 1'b0;
         ctr_q <= 1'b0;
      end else begin
         rd_mode_q <= rd_mode_d;
         ctr_q <= ctr_d;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   property p_rd_answer; rd_stb && !wr_stb && rd_mode_q |=> rd_valid; endproperty
   property p_rd_cause; rd_valid |-> $past(rd_stb) && $past(rd_mode_q); endproperty
   property p_rd_pulse; rd_valid |=> !rd_valid; endproperty
   // The byte may only change in the cycle in which its valid pulse stands
   property p_rd_hold; $changed(rdata) |-> rd_valid; endproperty
   property p_wr_pulse; wr_stb |=> !wr_stb; endproperty
   property p_excl; !(wr_stb && rd_stb); endproperty
   property p_ctr_top; wr_stb && dc && ctr_q |-> !wdata[7]; endproperty
   property p_quiet; $fell(SRST) |-> !wr_stb && !rd_stb && !rd_valid; endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read strobe in read state got no answer");
   a_rd_cause: assert property (p_rd_cause)
      else $error("read answer without read strobe in read state");
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read valid longer than one cycle");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read byte changed without valid");
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe longer than one cycle");
   a_excl: assert property (p_excl)
      else $error("write and read strobe together");
   a_ctr_top: assert property (p_ctr_top)
      else $error("contrast byte with top bit set");
   a_quiet: assert property (p_quiet)
      else $error("link busy right after reset");
   c_read: cover property (rd_valid);
   c_ctr: cover property (wr_stb && dc && ctr_q);
   c_pix: cover property (wr_stb && !dc && wdata == `LRW_CMD_PIX_WRITE);
endmodule : lrw_asserts

// ==== tb/lcd_ram_window_commands_bench.sv ====
`timescale 1ns/100ps
module lcd_ram_window_commands_bench;
   logic clk, srst, psel, penable, pwrite, strap, pscan, c256, pready, pslverr, e, dn, so;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0] pidx, v;
   logic [6:0] ctr;
   logic [3:0] pr, pgr, pb;
   int fail_count, cmp_count, fc, lc, fp, lp, col, pg, n;
   int mem[int];
   int lut[20];
   lrw_if lnk();
   lrw_device #(.NUM_COLS(104), .NUM_PAGES(84)) i_lrw_device (.CLK(clk), .SRST(srst), .LINK(lnk),
      .RAM_PARTITION_STRAP(strap), .PAGE_SCAN(pscan), .COLOUR_256(c256), .PIX_INDEX(pidx),
      .CONTRAST(ctr), .DISPLAY_ON(dn), .SEG_OFF(so), .PIX_R(pr), .PIX_G(pgr), .PIX_B(pb));
   lrw_host i_lrw_host (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(lnk));
   lrw_asserts chk (.CLK(clk), .SRST(srst), .dc(lnk.dc), .wr_stb(lnk.wr_stb), .wdata(lnk.wdata),
      .rd_stb(lnk.rd_stb), .rdata(lnk.rdata), .rd_valid(lnk.rd_valid));
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask : ck
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic send(input logic c, input logic [7:0] b);
      apb(1'b1, 12'h000, {23'h0, c, b});
   endtask : send
   task automatic stat();
      repeat (2) @(posedge clk);
      apb(1'b0, 12'h008, 32'h0);
   endtask : stat
   task automatic cmd(input logic [7:0] b);
      send(1'b0, b);
      if (b == 8'h2C || b == 8'h2E) begin
         col = fc;
         pg = fp;
      end
   endtask : cmd
   task automatic adv();
      if (!pscan) begin
         if (col == lc) begin
            col = fc;
            pg = (pg + 1) & 255;
         end else col = (col + 1) & 255;
      end else if (pg == lp) begin
         pg = fp;
         col = (col + 1) & 255;
      end else pg = (pg + 1) & 255;
   endtask : adv
   task automatic wpix(input logic [7:0] b);
      send(1'b1, b);
      if (col < 104 && pg < 84) mem[pg * 104 + col] = b;
      adv();
   endtask : wpix
   task automatic rpix();
      int x;
      // Clear the sticky valid flag first so every read proves its own answer
      apb(1'b1, 12'h008, 32'h100);
      apb(1'b1, 12'h004, 32'h0);
      stat();
      x = (col < 104 && pg < 84) ? mem[pg * 104 + col] : 0;
      ck(q[8:0], {1'b1, 8'(x)});
      adv();
   endtask : rpix
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
   initial begin
      {srst, psel, penable, pwrite, strap, pscan, c256, paddr, pwdata, pidx} = '0;
      void'($urandom(32'h2D498D36));
      for (int s = 0; s < 4; s++) begin
         srst <= 1'b1;
         strap <= s[0];
         pscan <= s[1];
         repeat (12) @(posedge clk);
         srst <= 1'b0;
         {fc, fp, lc, lp} = {32'd0, 32'd0, s[0] ? 32'd97 : 32'd103, s[0] ? 32'd66 : 32'd83};
         ck(ctr, 7'h3F);
         ck({dn, so}, 2'b01);
         n = (s[1] ? lp : lc) + 2;
         cmd(8'h2C);
         repeat (n) wpix(8'($urandom));
         cmd(8'h2E);
         repeat (n) rpix();
      end
      for (int k = 0; k < 4; k++) begin
         v = (k == 1) ? 8'hFF : (k == 0) ? 8'h00 : 8'($urandom);
         cmd(8'h25);
         send(1'b1, v);
         send(1'b1, ~v);
         repeat (3) @(posedge clk);
         ck(ctr, v[6:0]);
      end
      pscan <= 1'b0;
      cmd(8'h29);
      repeat (3) @(posedge clk);
      ck({dn, so}, 2'b10);
      // Window straddles the right RAM edge and the scan runs past the lower one, so some writes must vanish
      {fc, lc, fp, lp} = {32'd100, 32'd105, 32'd82, 32'd83};
      cmd(8'h2A);
      send(1'b1, 8'd100);
      send(1'b1, 8'd105);
      cmd(8'h2B);
      send(1'b1, 8'd82);
      send(1'b1, 8'd83);
      cmd(8'h2C);
      repeat (18) wpix(8'($urandom));
      cmd(8'h2C);
      repeat (3) wpix(8'($urandom));
      cmd(8'h29);
      send(1'b1, 8'hA5);
      cmd(8'h2E);
      repeat (18) rpix();
      cmd(8'h2A);
      send(1'b1, 8'h05);
      send(1'b1, 8'h05);
      stat();
      ck(q[9], 1'b1);
      apb(1'b1, 12'h008, 32'h200);
      stat();
      ck(q[9], 1'b0);
      cmd(8'h2B);
      send(1'b1, 8'h0A);
      send(1'b1, 8'h03);
      stat();
      ck(q[9], 1'b1);
      cmd(8'h2D);
      for (int i = 0; i < 20; i++) begin
         lut[i] = $urandom & 255;
         send(1'b1, 8'(lut[i]));
      end
      send(1'b1, 8'h0F);
      stat();
      ck(q[10], 1'b1);
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         c256 <= m[0];
         repeat (8) begin
            @(posedge clk);
            v = 8'($urandom);
            pidx <= v;
            repeat (2) @(posedge clk);
            @(negedge clk);
            if (m == 1) ck({pr, pgr, pb}, {4'(lut[v[7:5]]), 4'(lut[8 + v[4:2]]), 4'(lut[16 + v[1:0]])});
            else ck({pr, pgr, pb}, {v[7:5], 1'b0, v[4:2], 1'b0, v[1:0], 2'b00});
         end
      end
      cmd(8'h28);
      repeat (3) @(posedge clk);
      ck({dn, so, pr, pgr, pb}, 14'h1000);
      apb(1'b0, 12'h00C, 32'h0);
      ck(e, 1'b1);
      ck(q, 32'h0);
      report_and_stop();
   end
endmodule : lcd_ram_window_commands_bench
